// [src/fupe_ctrl.sv]
// fupe_ctrl: host-side sequencer that downloads, initialises and runs the flash programming routine.
// assumes the flash device answers each command on dev_cmd with a four-phase dev_ack handshake.
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module fupe_ctrl
    import fupe_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output fupe_dreq_s       dev_cmd,
    input  wire logic        dev_ack,
    input  wire logic [7:0]  dev_result,
    output logic [1:0]       cc_mask,
    output logic             bus_hold
);
    typedef enum logic [4:0] {S_IDLE, S_SEL, S_BASE, S_KEYA5, S_DL, S_KEYCLR1, S_CHKDL, S_INIT,
                              S_CHKINIT, S_MASK, S_KEY5A, S_CHKADDR, S_PROG, S_CHKPROG, S_FINKEY,
                              S_END, S_WAIT, S_WAITLO} fupe_state_e;

    fupe_state_e state_reg;
    fupe_state_e ret_reg;
    fupe_cfg_s   cfg;
    fupe_sts_s   sts;
    logic        start;
    logic        ack_s;
    logic        block_reg;
    logic [7:0]  key_reg;
    logic [31:0] dest_reg;
    logic [31:0] src_reg;
    logic [15:0] left_reg;
    logic [31:0] hwm_reg;
    logic        hwm_valid_reg;
    logic        prog_call;
    logic        init_call;

    fupe_regs u_regs (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .cfg       (cfg),
        .start     (start),
        .sts       (sts)
    );

    fupe_sync u_ack_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (dev_ack),
        .q     (ack_s)
    );

    function automatic fupe_dreq_s mk(fupe_op_e op, logic [31:0] addr, logic [31:0] gr0,
                                      logic [31:0] gr1, logic [7:0] data);
        fupe_dreq_s r;
        r = '{req: 1'b1, op: op, addr: addr, gr0: gr0, gr1: gr1, data: data};
        return r;
    endfunction : mk

    assign prog_call = dev_cmd.req && dev_cmd.op == OP_CALL && dev_cmd.addr == cfg.base + PROG_OFS;
    assign init_call = dev_cmd.req && dev_cmd.op == OP_CALL && dev_cmd.addr == cfg.base + INIT_OFS;

    // sequencer; hsize is ignored, only word transfers are expected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg     <= S_IDLE;
            ret_reg       <= S_IDLE;
            dev_cmd       <= '0;
            sts           <= '{busy: 1'b0, done: 1'b0, err: E_NONE, result: 8'h00, dl_result: 8'h00};
            key_reg       <= KEY_CLR;
            dest_reg      <= WORD_RST;
            src_reg       <= WORD_RST;
            left_reg      <= UNITS_RST;
            hwm_reg       <= WORD_RST;
            hwm_valid_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                S_IDLE: if (start) begin
                    sts.busy  <= 1'b1;
                    sts.done  <= 1'b0;
                    sts.err   <= E_NONE;
                    dest_reg  <= cfg.dest;
                    src_reg   <= cfg.src;
                    left_reg  <= cfg.units;
                    state_reg <= S_SEL;
                end
                S_SEL: begin
                    // exactly one routine selected
                    dev_cmd   <= mk(OP_WR_SEL, WORD_RST, WORD_RST, WORD_RST, cfg.erase ? SEL_ERASE : SEL_PROG);
                    ret_reg   <= S_BASE;
                    state_reg <= S_WAIT;
                end
                S_BASE: begin
                    // software keeps its 128-byte stack clear of the routine area named here
                    dev_cmd   <= mk(OP_WR_BASE, cfg.base, WORD_RST, WORD_RST, 8'h00);
                    ret_reg   <= S_KEYA5;
                    state_reg <= S_WAIT;
                end
                S_KEYA5: begin
                    dev_cmd   <= mk(OP_WR_KEY, WORD_RST, WORD_RST, WORD_RST, KEY_DL);
                    ret_reg   <= S_DL;
                    state_reg <= S_WAIT;
                end
                S_DL: begin
                    // the download brings the initialisation routine too
                    // request comes from this sequencer, never from code in the array
                    dev_cmd   <= mk(OP_DOWNLOAD, cfg.base, WORD_RST, WORD_RST, 8'h00);
                    ret_reg   <= S_KEYCLR1;
                    state_reg <= S_WAIT;
                end
                S_KEYCLR1: begin
                    dev_cmd   <= mk(OP_WR_KEY, WORD_RST, WORD_RST, WORD_RST, KEY_CLR);
                    ret_reg   <= S_CHKDL;
                    state_reg <= S_WAIT;
                end
                S_CHKDL: if (sts.dl_result == RES_OK) begin
                    state_reg <= S_INIT;
                end else begin
                    sts.err   <= sts.dl_result[DL_SEL_BIT] ? E_DL_SEL : E_DL;
                    state_reg <= S_END;
                end
                S_INIT: begin
                    // frequency range check is the routine's job; passed through untouched
                    dev_cmd   <= mk(OP_CALL, cfg.base + INIT_OFS, cfg.freq, WORD_RST, 8'h00);
                    ret_reg   <= S_CHKINIT;
                    state_reg <= S_WAIT;
                end
                S_CHKINIT: if (sts.result != RES_OK) begin
                    sts.err   <= E_INIT;
                    state_reg <= S_END;
                end else begin
                    // erase path stops once its routine is ready; block erase is driven elsewhere
                    state_reg <= cfg.erase ? S_END : S_MASK;
                end
                S_MASK: state_reg <= S_KEY5A;
                S_KEY5A: begin
                    dev_cmd   <= mk(OP_WR_KEY, WORD_RST, WORD_RST, WORD_RST, KEY_PROG);
                    ret_reg   <= S_CHKADDR;
                    state_reg <= S_WAIT;
                end
                S_CHKADDR: if (left_reg == UNITS_RST) begin
                    state_reg <= S_FINKEY;
                end else if (dest_reg[7:0] != ALIGN_LO0 && dest_reg[7:0] != ALIGN_LO1) begin
                    sts.err   <= E_ALIGN;
                    state_reg <= S_FINKEY;
                end else if (hwm_valid_reg && dest_reg < hwm_reg) begin
                    sts.err   <= E_REWRITE;
                    state_reg <= S_FINKEY;
                end else begin
                    state_reg <= S_PROG;
                end
                S_PROG: begin
                    dev_cmd   <= mk(OP_CALL, cfg.base + PROG_OFS, src_reg, dest_reg, 8'h00);
                    ret_reg   <= S_CHKPROG;
                    state_reg <= S_WAIT;
                end
                S_CHKPROG: if (sts.result == RES_OK) begin
                    dest_reg      <= dest_reg + UNIT_BYTES;
                    src_reg       <= src_reg + UNIT_BYTES;
                    left_reg      <= left_reg - 16'h0001;
                    hwm_reg       <= dest_reg + UNIT_BYTES;
                    hwm_valid_reg <= 1'b1;
                    state_reg     <= S_CHKADDR;
                end else begin
                    sts.err   <= E_PROG;
                    state_reg <= S_FINKEY;
                end
                S_FINKEY: begin
                    dev_cmd   <= mk(OP_WR_KEY, WORD_RST, WORD_RST, WORD_RST, KEY_CLR);
                    ret_reg   <= S_END;
                    state_reg <= S_WAIT;
                end
                S_END: begin
                    sts.busy  <= 1'b0;
                    sts.done  <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_WAIT: if (ack_s) begin
                    // result byte taken only on return, then held until the next call
                    dev_cmd.req <= 1'b0;
                    if (dev_cmd.op == OP_CALL) begin
                        sts.result <= dev_result;
                    end
                    if (dev_cmd.op == OP_DOWNLOAD) begin
                        sts.dl_result <= dev_result;
                    end
                    if (dev_cmd.op == OP_WR_KEY) begin
                        key_reg <= dev_cmd.data;
                    end
                    state_reg <= S_WAITLO;
                end
                S_WAITLO: if (!ack_s) begin
                    state_reg <= ret_reg;
                end
            endcase
        end
    end

    // interrupts stay open through initialisation; from arming until the job ends cc_mask[1] and bus_hold close, cc_mask[0] only with mode1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            block_reg <= 1'b0;
        end else if (state_reg == S_MASK) begin
            block_reg <= 1'b1;
        end else if (state_reg == S_END) begin
            block_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc_mask  <= 2'h0;
            bus_hold <= 1'b0;
        end else begin
            cc_mask  <= {block_reg, block_reg && cfg.mode1};
            bus_hold <= block_reg;
        end
    end

    property p_dl_keyed;
        @(posedge hclk) disable iff (!hresetn)
        $rose(dev_cmd.req) && dev_cmd.op == OP_DOWNLOAD |-> key_reg == KEY_DL;
    endproperty
    a_dl_keyed: assert property (p_dl_keyed) else $error("download without A5 key");

    property p_prog_armed;
        @(posedge hclk) disable iff (!hresetn)
        $rose(dev_cmd.req) && prog_call |-> key_reg == KEY_PROG && cc_mask[1] && bus_hold;
    endproperty
    a_prog_armed: assert property (p_prog_armed) else $error("program call not armed or masked");

    property p_init_open;
        @(posedge hclk) disable iff (!hresetn)
        init_call |-> !bus_hold && cc_mask == 2'h0;
    endproperty
    a_init_open: assert property (p_init_open) else $error("interrupts closed during init");

    property p_init_entry;
        @(posedge hclk) disable iff (!hresetn)
        state_reg == S_INIT |=> dev_cmd.req && dev_cmd.addr == cfg.base + 32'h0000_0020 && dev_cmd.gr0 == cfg.freq;
    endproperty
    a_init_entry: assert property (p_init_entry) else $error("init entry wrong");

    property p_prog_args;
        @(posedge hclk) disable iff (!hresetn)
        state_reg == S_PROG |=> dev_cmd.addr == cfg.base + 32'h0000_0010 && dev_cmd.gr1 == dest_reg
            && dev_cmd.gr0 == src_reg && dev_cmd.gr1[6:0] == 7'h00;
    endproperty
    a_prog_args: assert property (p_prog_args) else $error("program call arguments wrong");

    property p_advance;
        @(posedge hclk) disable iff (!hresetn)
        state_reg == S_CHKPROG && sts.result == RES_OK |=>
            dest_reg == $past(dest_reg) + 32'h0000_0080 && src_reg == $past(src_reg) + 32'h0000_0080;
    endproperty
    a_advance: assert property (p_advance) else $error("pointers not advanced by one unit");

    property p_key_cleared;
        @(posedge hclk) disable iff (!hresetn)
        $fell(sts.busy) |-> key_reg == KEY_CLR && !block_reg;
    endproperty
    a_key_cleared: assert property (p_key_cleared) else $error("job ended with key set");

    property p_cc_mode;
        @(posedge hclk) disable iff (!hresetn)
        $rose(block_reg) |=> cc_mask == {1'b1, cfg.mode1} ##1 cc_mask[1];
    endproperty
    a_cc_mode: assert property (p_cc_mode) else $error("mask bits wrong for mode");

    property p_result_hold;
        @(posedge hclk) disable iff (!hresetn)
        state_reg != S_WAIT |=> sts.result == $past(sts.result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result byte changed mid-call");

    property p_align;
        @(posedge hclk) disable iff (!hresetn)
        state_reg == S_CHKADDR && left_reg != 16'h0000 && dest_reg[6:0] != 7'h00 |=> sts.err == E_ALIGN;
    endproperty
    a_align: assert property (p_align) else $error("misaligned destination not refused");

    c_dl_ok:   cover property (@(posedge hclk) disable iff (!hresetn) state_reg == S_CHKDL && sts.dl_result == RES_OK);
    c_prog:    cover property (@(posedge hclk) disable iff (!hresetn) $rose(dev_cmd.req) && prog_call);
    c_err_end: cover property (@(posedge hclk) disable iff (!hresetn) $fell(sts.busy) && sts.err != E_NONE);
    c_erase:   cover property (@(posedge hclk) disable iff (!hresetn) $fell(sts.busy) && cfg.erase);
endmodule : fupe_ctrl

// [src/fupe_pkg.sv]
// fupe_pkg: constants, enums and carriers for the user-mode flash program/erase controller.
// assumes one hclk domain; the flash device is reached through a req/ack command port.
package fupe_pkg;
    // flash key values
    localparam logic [7:0]  KEY_DL     = 8'hA5;
    localparam logic [7:0]  KEY_PROG   = 8'h5A;
    localparam logic [7:0]  KEY_CLR    = 8'h00;
    // entry offsets above the download base, and the programming unit
    localparam logic [31:0] INIT_OFS   = 32'h0000_0020;
    localparam logic [31:0] PROG_OFS   = 32'h0000_0010;
    localparam logic [31:0] UNIT_BYTES = 32'h0000_0080;
    localparam logic [7:0]  ALIGN_LO0  = 8'h00;
    localparam logic [7:0]  ALIGN_LO1  = 8'h80;
    localparam logic [7:0]  RES_OK     = 8'h00;
    localparam int          DL_SEL_BIT = 2;
    // routine select byte: program select and erase select
    localparam logic [7:0]  SEL_PROG   = 8'h01;
    localparam logic [7:0]  SEL_ERASE  = 8'h02;
    // own registers, byte addresses
    localparam logic [7:0]  A_CTRL     = 8'h00;
    localparam logic [7:0]  A_BASE     = 8'h04;
    localparam logic [7:0]  A_DEST     = 8'h08;
    localparam logic [7:0]  A_SRC      = 8'h0C;
    localparam logic [7:0]  A_UNITS    = 8'h10;
    localparam logic [7:0]  A_FREQ     = 8'h14;
    localparam logic [7:0]  A_STATUS   = 8'h18;
    localparam int          CTRL_START = 0;
    localparam int          CTRL_ERASE = 1;
    localparam int          CTRL_MODE1 = 2;
    localparam logic [2:0]  CTRL_RST   = 3'h0;
    localparam logic [31:0] WORD_RST   = 32'h0000_0000;
    localparam logic [15:0] UNITS_RST  = 16'h0000;

    typedef enum logic [2:0] {OP_WR_KEY, OP_WR_SEL, OP_WR_BASE, OP_DOWNLOAD, OP_CALL} fupe_op_e;
    typedef enum logic [2:0] {E_NONE, E_DL, E_DL_SEL, E_INIT, E_ALIGN, E_REWRITE, E_PROG} fupe_err_e;

    typedef struct packed {
        logic        req;
        fupe_op_e    op;
        logic [31:0] addr;
        logic [31:0] gr0;
        logic [31:0] gr1;
        logic [7:0]  data;
    } fupe_dreq_s;

    typedef struct packed {
        logic        erase;
        logic        mode1;
        logic [31:0] base;
        logic [31:0] dest;
        logic [31:0] src;
        logic [31:0] freq;
        logic [15:0] units;
    } fupe_cfg_s;

    typedef struct packed {
        logic        busy;
        logic        done;
        fupe_err_e   err;
        logic [7:0]  result;
        logic [7:0]  dl_result;
    } fupe_sts_s;
endpackage : fupe_pkg

// [src/fupe_regs.sv]
// fupe_regs: AHB-Lite slave holding the controller's own command and status registers.
// assumes single word transfers; zero wait states, always OKAY; unmapped reads give zero.
`timescale 1ns/1ps
module fupe_regs
    import fupe_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output fupe_cfg_s        cfg,
    output logic             start,
    input  wire fupe_sts_s   sts
);
    logic       wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic       acc;

    assign acc = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= acc && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // read data prepared in the address phase so it stands during the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= WORD_RST;
        end else if (acc && !hwrite) begin
            unique case (haddr[7:0])
                A_CTRL:   hrdata <= {29'h0, cfg.mode1, cfg.erase, 1'b0};
                A_BASE:   hrdata <= cfg.base;
                A_DEST:   hrdata <= cfg.dest;
                A_SRC:    hrdata <= cfg.src;
                A_UNITS:  hrdata <= {16'h0, cfg.units};
                A_FREQ:   hrdata <= cfg.freq;
                A_STATUS: hrdata <= {8'h0, sts.dl_result, sts.result, 1'b0, sts.err, 2'h0, sts.done, sts.busy};
                default:  hrdata <= WORD_RST;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg   <= '{erase: 1'b0, mode1: 1'b0, base: WORD_RST, dest: WORD_RST,
                       src: WORD_RST, freq: WORD_RST, units: UNITS_RST};
            start <= 1'b0;
        end else begin
            start <= 1'b0;
            if (wr_pend_reg) begin
                unique case (wr_addr_reg)
                    A_CTRL: begin
                        start     <= hwdata[CTRL_START];
                        cfg.erase <= hwdata[CTRL_ERASE];
                        cfg.mode1 <= hwdata[CTRL_MODE1];
                    end
                    A_BASE:  cfg.base  <= hwdata;
                    A_DEST:  cfg.dest  <= hwdata;
                    A_SRC:   cfg.src   <= hwdata;
                    A_UNITS: cfg.units <= hwdata[15:0];
                    A_FREQ:  cfg.freq  <= hwdata;
                    default: ;
                endcase
            end
        end
    end
endmodule : fupe_regs

// [src/fupe_sync.sv]
// fupe_sync: three-flop input synchroniser; output moves once stages two and three agree.
// assumes d is asynchronous to clk.
`timescale 1ns/1ps
module fupe_sync
    import fupe_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic [2:0] sh_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_reg <= 3'h0;
        end else begin
            sh_reg <= {sh_reg[1:0], d};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (sh_reg[1] == sh_reg[2]) begin
            q <= sh_reg[2];
        end
    end
endmodule : fupe_sync

// [verif/fupe_dev_model.sv]
// fupe_dev_model: behavioural flash device on the controller's command port.
// assumes the hclk domain; acks alternately fast and slow.
`timescale 1ns/1ps
module fupe_dev_model
    import fupe_pkg::*;
#(parameter logic [31:0] USER_TOP = 32'h0004_0000)
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire fupe_dreq_s dev_cmd,
    input  wire logic [1:0] cc_mask,
    input  wire logic       bus_hold,
    output logic            dev_ack,
    output logic [7:0]      dev_result,
    output logic [7:0]      n_prog,
    output logic [31:0]     last_dest,
    output logic [7:0]      key,
    output logic [1:0]      mask_seen
);
    logic [7:0]  sel, res, wt;
    logic [31:0] base, hw;
    logic        slow;
    // result is only valid with ack; otherwise show garbage
    assign dev_result = dev_ack ? res : ~res;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {dev_ack, res, n_prog, last_dest, key, mask_seen, sel, wt, base, hw, slow} <= '0;
        end else if (dev_ack) begin
            dev_ack <= dev_cmd.req;
        end else if (dev_cmd.req && wt < (slow ? 8'h06 : 8'h01)) begin
            wt <= wt + 8'h01;
        end else if (dev_cmd.req) begin
            {wt, dev_ack, slow} <= {8'h00, 1'b1, ~slow};
            case (dev_cmd.op)
                OP_WR_KEY:   key <= dev_cmd.data;
                OP_WR_SEL:   sel <= dev_cmd.data;
                OP_WR_BASE:  base <= dev_cmd.addr;
                OP_DOWNLOAD: res <= (key != KEY_DL) ? 8'h02 :
                    ($countones(sel) != 1) ? 8'h04 : RES_OK;
                default: if (dev_cmd.addr == base + INIT_OFS) begin
                    res <= (dev_cmd.gr0 >= 32'h05 && dev_cmd.gr0 <= 32'h21) ? RES_OK : 8'h01;
                end else begin
                    {n_prog, last_dest, mask_seen} <= {n_prog + 8'h01, dev_cmd.gr1, cc_mask & {2{bus_hold}}};
                    res <= (dev_cmd.addr != base + PROG_OFS || key != KEY_PROG || !bus_hold || dev_cmd.gr1 >= USER_TOP
                        || dev_cmd.gr0 < USER_TOP || dev_cmd.gr1 < hw) ? 8'h01 : RES_OK;
                    hw <= dev_cmd.gr1 + UNIT_BYTES;
                end
            endcase
        end
    end
endmodule : fupe_dev_model

// [verif/tb.sv]
// tb: self-checking bench for fupe_ctrl with the flash device model.
// assumes one AHB-Lite master and slave, hclk at 50 MHz.
`timescale 1ns/1ps
module tb import fupe_pkg::*; ;
    logic        hclk, hresetn, hsel, hwrite, dev_ack, bus_hold, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, last_dest, rd;
    logic [1:0]  htrans, cc_mask, mask_seen;
    logic [2:0]  hsize;
    logic [7:0]  dev_result, n_prog, key;
    fupe_dreq_s  dev_cmd;
    int          n_fail, n_compared, cyc;
    fupe_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .dev_cmd(dev_cmd), .dev_ack(dev_ack), .dev_result(dev_result), .cc_mask(cc_mask), .bus_hold(bus_hold));
    fupe_dev_model dev (.hclk(hclk), .hresetn(hresetn), .dev_cmd(dev_cmd), .cc_mask(cc_mask), .bus_hold(bus_hold),
        .dev_ack(dev_ack), .dev_result(dev_result), .n_prog(n_prog), .last_dest(last_dest), .key(key),
        .mask_seen(mask_seen));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task automatic summarize();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite, hsize} <= {1'b1, 24'h0, a, 2'h2, wr, 3'h2};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic job(input logic [2:0] ctl, input logic [31:0] dst, input logic [31:0] src,
                       input logic [15:0] units, input logic [31:0] frq, input logic [2:0] err);
        int n;
        ahb(1'b1, A_BASE, 32'h0000_1000);
        ahb(1'b1, A_DEST, dst);
        ahb(1'b1, A_SRC, src);
        ahb(1'b1, A_UNITS, {16'h0000, units});
        ahb(1'b1, A_FREQ, frq);
        ahb(1'b1, A_CTRL, {29'h0, ctl});
        n = 0;
        do begin
            ahb(1'b0, A_STATUS, 32'h0);
            n++;
        end while ((rd[0] !== 1'b0 || n < 3) && n < 3000);
        chk({31'h0, rd[0]}, 32'h0);
        chk({29'h0, rd[6:4]}, {29'h0, err});
        if (err === 3'h0) chk({31'h0, rd[1]}, 32'h1);
        chk({24'h0, key}, {24'h0, KEY_CLR});
        chk({28'h0, hresp, cc_mask, bus_hold}, 32'h0);
    endtask : job
    task automatic t_regs();
        ahb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        for (int a = 0; a <= 28; a += 4) begin
            ahb(1'b0, a[7:0], 32'h0);
            chk(rd, WORD_RST);
        end
        ahb(1'b1, A_DEST, 32'h0000_0180);
        ahb(1'b0, A_DEST, 32'h0);
        chk(rd, 32'h0000_0180);
    endtask : t_regs
    task automatic t_prog();
        job(3'h5, 32'h0000_0100, 32'h2000_0000, 16'h0002, 32'h21, 3'h0);
        chk({24'h0, n_prog}, 32'h2);
        chk(last_dest, 32'h0000_0180);
        chk({30'h0, mask_seen}, 32'h3);
        job(3'h1, 32'h0000_0200, 32'h2000_0000, 16'h0001, 32'h05, 3'h0);
        chk({30'h0, mask_seen}, 32'h2);
        chk({16'h0, rd[23:8]}, 32'h0);
    endtask : t_prog
    task automatic t_refuse();
        job(3'h1, 32'h0000_0100, 32'h2000_0000, 16'h0001, 32'h21, 3'h5);
        job(3'h1, 32'h0000_0240, 32'h2000_0000, 16'h0001, 32'h21, 3'h4);
        job(3'h1, 32'h0000_0400, 32'h2000_0000, 16'h0001, 32'h04, 3'h3);
        job(3'h1, 32'h0000_0400, 32'h2000_0000, 16'h0001, 32'h22, 3'h3);
        chk({24'h0, rd[15:8]}, 32'h1);
        job(3'h1, 32'h0000_0400, 32'h0000_0100, 16'h0001, 32'h21, 3'h6);
        job(3'h1, 32'h0004_0000, 32'h2000_0000, 16'h0001, 32'h21, 3'h6);
    endtask : t_refuse
    task automatic t_erase();
        logic [7:0] n0;
        n0 = n_prog;
        job(3'h3, 32'h0000_0800, 32'h2000_0000, 16'h0001, 32'h21, 3'h0);
        chk({24'h0, n_prog}, {24'h0, n0});
    endtask : t_erase
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_regs();
        t_prog();
        t_refuse();
        t_erase();
        summarize();
    end
endmodule : tb
